// file: src/ppl_pkg.sv
package ppl_pkg;

  localparam int NUM_PEDALS = 13;
  localparam int OCTAVES    = 5;

  // base tick rate: master_frequency in the low-rate setting, or a quarter of it in the fast setting
  localparam longint BASE_FREQ_HZ  = 500060;
  localparam int     FAST_PRESCALE = 4;

  // percussion_pulse_period and sustain debounce window, as times
  localparam longint TP_WIDTH_US = 10000;
  localparam longint DEB_TIME_US = 1000;
  localparam int     TP_TICKS    = int'((BASE_FREQ_HZ * TP_WIDTH_US) / 1000000);
  localparam int     DEB_TICKS   = int'((BASE_FREQ_HZ * DEB_TIME_US) / 1000000);

  // acceptance delay is eight half periods (four cycles) of the pedal's top tone
  localparam int DELAY_SHIFT = 3;

  // half period of the top (1') tone in base ticks, leftmost pedal first
  localparam logic [8:0] HALF_TICKS [NUM_PEDALS] = '{
    9'h1DE, 9'h1C3, 9'h1AA, 9'h192, 9'h17B, 9'h166, 9'h152,
    9'h13F, 9'h12D, 9'h11C, 9'h10C, 9'h0FD, 9'h0EF
  };

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_HOLD, ST_REL} ppl_phase_type;

  typedef struct packed {
    logic [1:0]            freq_sync;
    logic [1:0]            mode_sync;
    logic [NUM_PEDALS-1:0] ped_s1;
    logic [NUM_PEDALS-1:0] ped_s2;
    logic [NUM_PEDALS-1:0] ped_prev;
    logic                  freq_prev;
    logic [1:0]            pre;
    ppl_phase_type         phase;
    logic [3:0]            sel;
    logic                  sel_valid;
    logic [3:0]            cand;
    logic [11:0]           delay;
    logic [8:0]            div;
    logic [OCTAVES-1:0]    tone;
    logic [12:0]           tp;
    logic                  ts;
    logic [9:0]            deb;
  } ppl_state_type;

  localparam ppl_state_type PPL_RESET_STATE = '0;

endpackage

// file: src/ppl_pedal_latch.sv
`timescale 1ns/1ps
module ppl_pedal_latch
  import ppl_pkg::*;
#(
  parameter int TP_TICKS_P = TP_TICKS
) (
  // clock and reset
  input  wire logic                  CLK,
  input  wire logic                  RESETN,
  // master frequency and rate select (high: negative rail, fast master)
  input  wire logic                  MASTER_FREQUENCY,
  input  wire logic                  MODE,
  // pedal switches, active low, leftmost is index 0
  input  wire logic [NUM_PEDALS-1:0] PEDAL_N,
  // outputs: bit 0 is the 1' octave, bit 4 the 16'
  output logic      [OCTAVES-1:0]    TONE,
  output logic                       SUSTAIN_TRIGGER,
  output logic                       PERCUSSION_TRIGGER
);

  function automatic logic [8:0] half_of(input logic [3:0] idx);
    half_of = (idx < 4'(NUM_PEDALS)) ? HALF_TICKS[idx] : HALF_TICKS[0];
  endfunction

  function automatic logic [11:0] delay_of(input logic [3:0] idx);
    delay_of = 12'(half_of(idx)) << DELAY_SHIFT;
  endfunction

  function automatic logic [3:0] leftmost(input logic [NUM_PEDALS-1:0] v);
    leftmost = 4'h0;
    // scanned from the right so the lowest index found last wins
    for (int i = NUM_PEDALS - 1; i >= 0; i--) begin
      if (v[i]) begin
        leftmost = 4'(i);
      end
    end
  endfunction

  logic [1:0]    rst_sync_r;
  logic          rst_n;
  ppl_state_type st_r;
  ppl_state_type st_nxt;

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  // reset takes hold at once but is let go in step with CLK
  assign rst_n = rst_sync_r[1];

  always_comb begin
    logic                  rise;
    logic                  tick;
    logic                  any;
    logic                  accept;
    logic [3:0]            left;
    logic [NUM_PEDALS-1:0] press;
    logic [NUM_PEDALS-1:0] lower;
    logic [NUM_PEDALS-1:0] held;
    rise   = 1'b0;
    tick   = 1'b0;
    any    = 1'b0;
    accept = 1'b0;
    left   = 4'h0;
    press  = '0;
    lower  = '0;
    held   = '0;
    st_nxt = st_r;

    // pins cross into CLK through two flops before anything reads them
    st_nxt.freq_sync = {st_r.freq_sync[0], MASTER_FREQUENCY};
    st_nxt.mode_sync = {st_r.mode_sync[0], MODE};
    st_nxt.ped_s1    = PEDAL_N;
    st_nxt.ped_s2    = st_r.ped_s1;
    st_nxt.freq_prev = st_r.freq_sync[1];
    // raw levels pass both flops untouched; polarity is flipped only after the second one
    // the zeroed stages after reset are never used: no tick can come before both have filled
    held = ~st_r.ped_s2;

    rise = st_r.freq_sync[1] & ~st_r.freq_prev;
    if (rise) begin
      st_nxt.pre = st_r.pre + 2'h1;
    end
    // fast master is prescaled so every count below scales with it
    tick = rise && (!st_r.mode_sync[1] || st_r.pre == 2'(FAST_PRESCALE - 1));
    // a tick is one CLK wide, so each counter below moves once per tick

    any   = |held;
    left  = leftmost(held);
    press = held & ~st_r.ped_prev;
    lower = NUM_PEDALS'((NUM_PEDALS'(1) << st_r.sel) - NUM_PEDALS'(1));

    if (tick) begin
      st_nxt.ped_prev = held;
      // delay stops at zero, so an expiry seen late still counts
      if (st_r.delay != 12'h0) begin
        st_nxt.delay = st_r.delay - 12'h1;
      end
      // the pulse ends on its own count; no event shortens it
      if (st_r.tp != 13'h0) begin
        st_nxt.tp = st_r.tp - 13'h1;
      end

      unique case (st_r.phase)
        ST_IDLE: begin
          // only the leftmost held pedal can become the candidate
          if (any) begin
            st_nxt.cand  = left;
            st_nxt.delay = delay_of(left);
            st_nxt.phase = ST_WAIT;
          end
        end
        ST_WAIT: begin
          // a different leftmost pedal restarts the delay with its own length
          if (!any) begin
            st_nxt.phase = ST_IDLE;
          end else if (left != st_r.cand) begin
            st_nxt.cand  = left;
            st_nxt.delay = delay_of(left);
          end else if (st_r.delay == 12'h0) begin
            accept = 1'b1;
          end
        end
        ST_HOLD: begin
          // pedals to the right are ignored while the selected one is held
          if (!held[st_r.sel]) begin
            if (any) begin
              accept = 1'b1;
            end else begin
              st_nxt.delay = delay_of(st_r.sel);
              st_nxt.phase = ST_REL;
            end
          end else if ((press & lower) != '0) begin
            accept = 1'b1;
          end
        end
        ST_REL: begin
          // release delay: only a pedal to the left can cut it short
          if (any && left < st_r.sel) begin
            accept = 1'b1;
          end else if (st_r.delay == 12'h0) begin
            st_nxt.phase = ST_IDLE;
          end
        end
      endcase

      // every acceptance path meets here, so a new pulse never starts without the phase clear
      if (accept) begin
        st_nxt.sel       = left;
        st_nxt.sel_valid = 1'b1;
        st_nxt.phase     = ST_HOLD;
        // same pedal again restarts its phase from zero
        st_nxt.div       = 9'h0;
        st_nxt.tone      = '0;
        // a pulse still running swallows the second press
        if (st_r.tp == 13'h0) begin
          st_nxt.tp = 13'(TP_TICKS_P);
        end
      end else if (st_r.sel_valid) begin
        // tone keeps running after release until a new acceptance
        if (st_r.div == half_of(st_r.sel) - 9'h1) begin
          st_nxt.div     = 9'h0;
          st_nxt.tone[0] = ~st_r.tone[0];
          if (!st_r.tone[0]) begin
            st_nxt.tone[OCTAVES-1:1] = st_r.tone[OCTAVES-1:1] + 4'h1;
          end
        end else begin
          st_nxt.div = st_r.div + 9'h1;
        end
      end

      // sustain follows the held state only after it has been stable
      // limitation: a bounce longer than the window still reaches the output
      if (any != st_r.ts) begin
        if (st_r.deb == 10'(DEB_TICKS - 1)) begin
          st_nxt.ts  = any;
          st_nxt.deb = 10'h0;
        end else begin
          st_nxt.deb = st_r.deb + 10'h1;
        end
      end else begin
        st_nxt.deb = 10'h0;
      end
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= PPL_RESET_STATE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign TONE               = st_r.tone;
  assign SUSTAIN_TRIGGER    = st_r.ts;
  // decoded from a registered count, so the pulse cannot glitch
  assign PERCUSSION_TRIGGER = (st_r.tp != 13'h0);

endmodule

// file: test/ppl_pedal_latch_checker.sv
`timescale 1ns/1ps
module ppl_pedal_latch_checker
  import ppl_pkg::*;
#(
  parameter int TP_TICKS_P = TP_TICKS
) (
  // clock and reset
  input wire logic                  CLK,
  input wire logic                  RESETN,
  // inputs
  input wire logic                  MASTER_FREQUENCY,
  input wire logic                  MODE,
  input wire logic [NUM_PEDALS-1:0] PEDAL_N,
  // outputs
  input wire logic [OCTAVES-1:0]    TONE,
  input wire logic                  SUSTAIN_TRIGGER,
  input wire logic                  PERCUSSION_TRIGGER
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  reset_quiet_a: assert property (disable iff (1'b0) !RESETN |=> TONE == '0 && !PERCUSSION_TRIGGER)
    else $error("output active in reset");
  perc_width_a: assert property ($rose(PERCUSSION_TRIGGER) |-> PERCUSSION_TRIGGER[*8])
    else $error("percussion pulse too short");
  perc_cause_a: assert property ($rose(PERCUSSION_TRIGGER) |-> $past(PEDAL_N, 4) != '1)
    else $error("percussion pulse without pedal");
  perc_clear_a: assert property ($rose(PERCUSSION_TRIGGER) |-> TONE == '0)
    else $error("tone not cleared on acceptance");
  sus_rise_a: assert property ($rose(SUSTAIN_TRIGGER) |-> $past(PEDAL_N, 4) != '1)
    else $error("sustain rose with no pedal");
  sus_fall_a: assert property ($fell(SUSTAIN_TRIGGER) |-> &$past(PEDAL_N, 4))
    else $error("sustain fell with pedal held");
  tone_step_a: assert property ($changed(TONE[4:1]) && TONE != '0 |-> TONE[4:1] == $past(TONE[4:1]) + 4'h1)
    else $error("lower octaves skipped a step");
  tone_src_a: assert property ($changed(TONE[4:1]) |-> TONE[0] || TONE == '0)
    else $error("lower octave moved off top rise");
  cover property ($rose(PERCUSSION_TRIGGER) && PEDAL_N != '1);
  cover property ($fell(SUSTAIN_TRIGGER));
  cover property ($rose(TONE[2]));
  cover property (MODE && $changed(TONE[0]));
endmodule

bind ppl_pedal_latch ppl_pedal_latch_checker #(.TP_TICKS_P(TP_TICKS_P)) u_chk (
  .CLK(CLK), .RESETN(RESETN), .MASTER_FREQUENCY(MASTER_FREQUENCY), .MODE(MODE), .PEDAL_N(PEDAL_N),
  .TONE(TONE), .SUSTAIN_TRIGGER(SUSTAIN_TRIGGER), .PERCUSSION_TRIGGER(PERCUSSION_TRIGGER));

// file: test/ppl_pedal_model.sv
`timescale 1ns/1ps
module ppl_pedal_model
  import ppl_pkg::*;
(
  // bench commands
  input  wire logic                  clk,
  input  wire logic [NUM_PEDALS-1:0] press,
  // pins
  output logic                       master_frequency,
  output logic [NUM_PEDALS-1:0]      pedal_n
);
  logic [2:0] div_r = 3'h0;
  // free-running scaled master, eight clk per period, so long delays fit the run
  always @(posedge clk) div_r <= div_r + 3'h1;
  assign master_frequency = div_r[2];
  // a closed switch pulls low; presses are held far beyond half a pulse period
  assign pedal_n = ~press;
endmodule

// file: test/tb.sv
`timescale 1ns/1ps
module tb;
  import ppl_pkg::*;
  localparam int MP = 8;
  logic                  clk = 1'b0;
  logic                  resetn;
  logic                  mode;
  logic                  mf;
  logic [NUM_PEDALS-1:0] press;
  logic [NUM_PEDALS-1:0] pedal_n;
  logic [OCTAVES-1:0]    tone;
  logic                  sus;
  logic                  perc;
  logic [15:0]           rnd;
  int                    err_total;
  int                    checked;
  int                    n;
  int                    k;
  always #10 clk = ~clk;
  ppl_pedal_model PM (.clk(clk), .press(press), .master_frequency(mf), .pedal_n(pedal_n));
  ppl_pedal_latch #(.TP_TICKS_P(50)) DUT (.CLK(clk), .RESETN(resetn), .MASTER_FREQUENCY(mf), .MODE(mode),
    .PEDAL_N(pedal_n), .TONE(tone), .SUSTAIN_TRIGGER(sus), .PERCUSSION_TRIGGER(perc));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // clocks per half period of the top tone of pedal p, slow or fast rate
  function automatic int half_clk(input int p, input logic fast);
    return int'(HALF_TICKS[p]) * MP * (fast ? FAST_PRESCALE : 1);
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    if (err_total == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  // sel 0 watches percussion, sel 1 the top tone
  task automatic wait_for(input int sel, input logic v, input int lim, output int c);
    c = 0;
    while ((sel == 0 ? perc : tone[0]) !== v) begin
      cyc(1);
      c++;
      if (c > lim) begin
        err_total++;
        tally_and_finish();
      end
    end
  endtask
  initial begin
    resetn = 1'b0;
    mode = 1'b0;
    press = '0;
    err_total = 0;
    checked = 0;
    rnd = lfsr(16'h9424);
    cyc(3);
    resetn = 1'b1;
    cyc(4);
    k = rnd % 12;
    press[k] = 1'b1;
    cyc(100 * MP);
    press = '0;
    n = 0;
    repeat (400 * MP) begin
      cyc(1);
      if (perc === 1'b1) n++;
    end
    chk("short press pulse", n, 0);
    chk("tone after short press", tone, 0);
    press[12] = 1'b1;
    wait_for(0, 1'b1, 40000, n);
    chk("delay low", n >= 8 * HALF_TICKS[12] * MP, 1);
    chk("delay high", n <= 8 * HALF_TICKS[12] * MP + 6 * MP, 1);
    chk("sustain", sus, 1);
    wait_for(1, 1'b1, 300 * MP, n);
    wait_for(1, 1'b0, 300 * MP, n);
    chk("high half", n, HALF_TICKS[12] * MP);
    wait_for(1, 1'b1, 300 * MP, n);
    chk("low half", n, HALF_TICKS[12] * MP);
    rnd = lfsr(rnd);
    k = rnd % 12;
    press[k] = 1'b1;
    wait_for(0, 1'b1, 6 * MP, n);
    chk("left taken", tone, 0);
    wait_for(1, 1'b1, 500 * MP, n);
    wait_for(1, 1'b0, 500 * MP, n);
    chk("left half", n, half_clk(k, 1'b0));
    cyc(60 * MP);
    press[k] = 1'b0;
    wait_for(0, 1'b1, 6 * MP, n);
    press = '0;
    cyc(600 * MP);
    chk("sustain off", sus, 0);
    wait_for(1, ~tone[0], 300 * MP, n);
    mode = 1'b1;
    wait_for(1, ~tone[0], 1000 * MP, n);
    wait_for(1, ~tone[0], 1000 * MP, n);
    chk("fast half", n, half_clk(12, 1'b1));
    tally_and_finish();
  end
endmodule
